//--- include/nsid_map.svh
// Byte offsets, field positions, widths and reset values of the field block
`ifndef NSID_MAP_SVH
`define NSID_MAP_SVH
`define NSID_FIRST_BYTE   8'd66
`define NSID_LAST_BYTE    8'd103
`define NSID_OFF_PWALIGN  8'd66
`define NSID_OFF_DGRAN    8'd68
`define NSID_OFF_DALIGN   8'd70
`define NSID_OFF_OWSIZE   8'd72
`define NSID_OFF_AGID     8'd92
`define NSID_OFF_ATTR     8'd99
`define NSID_OFF_SETID    8'd100
`define NSID_OFF_ENDURANCE_GROUP_ID   8'd102
`define NSID_ATTR_WP_BIT  0
`define NSID_RST_HALF     16'h0000
`define NSID_RST_WORD     32'h00000000
`define NSID_RST_BYTE     8'h00
`endif

//--- include/nsid_pkg.sv
// Types shared by the namespace identify field block
package nsid_pkg;
  typedef logic [15:0] nsid_half_t;
  typedef logic [31:0] nsid_word_t;
  typedef logic [7:0]  nsid_byte_t;
  // Read engine states, Gray along idle -> load -> answer
  typedef enum logic [1:0] {
    NSID_IDLE = 2'b00,
    NSID_LOAD = 2'b01,
    NSID_ANS  = 2'b11
  } nsid_state_e;
endpackage

//--- include/nsid_chk_if.sv
// Carrier between the top and the write-protect gate
`timescale 1ns/1ps
`default_nettype none
interface nsid_chk_if;
  logic wrReq;     // Host write arriving
  logic wrProt;    // Current protection state
  logic wrFail;    // Write must be failed
  logic wrPass;    // Write may proceed
  modport gate (input wrReq, input wrProt, output wrFail, output wrPass);
  modport top  (output wrReq, output wrProt, input wrFail, input wrPass);
endinterface
`default_nettype wire

//--- verilog/nsid_wp_gate.sv
// Write-protect gate: fails every write while the namespace is protected
`timescale 1ns/1ps
`default_nettype none
module nsid_wp_gate (
  nsid_chk_if.gate chk
);
  import nsid_pkg::*;
  // Pure decode; the top registers the verdict
  always_comb begin
    chk.wrFail = chk.wrReq & chk.wrProt;   // [R12]
    chk.wrPass = chk.wrReq & ~chk.wrProt;
  end
endmodule
`default_nettype wire

//--- verilog/nsid_fields.sv
// Namespace identify fields, bytes 66 to 103, byte-read port
`timescale 1ns/1ps
`default_nettype none
`include "nsid_map.svh"
// Notes on behaviour
// [R1] Bytes 67:66 give zero-based write alignment
// [R2] Bytes 69:68 give zero-based deallocate granularity
// [R3] Optimisation flag clear: those fields read reserved; bytes 67:66 still return the write alignment
// [R4] Granularity should be multiple of alignment
// [R5] Bytes 71:70 give zero-based deallocate alignment
// [R6] Bytes 73:72 give zero-based optimal write size
// [R7] Optimal size within limit, multiple of granularity
// [R8] Values may change on reformat only
// [R9] Access reporting on: report valid group id
// [R10] Access reporting off: group id reads zero
// [R11] Group id change raises access change notice
// [R12] Protect bit set: every write fails
// [R13] Attribute bits 7:1 reserved, read zero
// [R14] Bytes 101:100 set id, zero if unsupported
// [R15] Bytes 103:102 endurance id, zero if unsupported
// [R16] Write granularity is zero-based, logical blocks
// [R17] Reserved bytes in range read zero
module nsid_fields (
  input  wire logic              clk,
  input  wire logic              rst,
  // Field sources from the namespace manager
  input  wire nsid_pkg::nsid_half_t prefWriteAlign,
  input  wire nsid_pkg::nsid_half_t prefDeallocGran,
  input  wire nsid_pkg::nsid_half_t prefDeallocAlign,
  input  wire nsid_pkg::nsid_half_t optimalWriteSize,
  input  wire nsid_pkg::nsid_half_t prefWriteGran,
  input  wire nsid_pkg::nsid_half_t maxTransferLimit,
  input  wire logic              optimParamsSupported,
  input  wire logic              reformatDone,
  input  wire nsid_pkg::nsid_word_t accessGroupId,
  input  wire logic              accessReportSupported,
  input  wire logic              accessNoticeEnabled,
  input  wire logic              writeProtected,
  input  wire nsid_pkg::nsid_half_t storageSetId,
  input  wire logic              storageSetSupported,
  input  wire nsid_pkg::nsid_half_t enduranceGroupId,
  input  wire logic              enduranceSupported,
  // Byte read port
  input  wire logic              rdReq,
  input  wire nsid_pkg::nsid_byte_t rdAddr,
  output logic                   rdValid,
  output nsid_pkg::nsid_byte_t   rdData,
  // Write check port
  input  wire logic              wrReq,
  output logic                   wrFail,
  output logic                   wrOk,
  // Events
  output logic                   accessChangeNotice,
  output logic                   hintsInconsistent
);
  import nsid_pkg::*;

  // Latched field image, refreshed at reset release and on reformat
  nsid_half_t  alignReg, alignNext;        // Write alignment
  nsid_half_t  dGranReg, dGranNext;        // Deallocate granularity
  nsid_half_t  dAlignReg, dAlignNext;      // Deallocate alignment
  nsid_half_t  owsReg, owsNext;            // Optimal write size
  logic        optReg, optNext;            // Optimisation flag copy
  logic        loadedReg, loadedNext;      // Image taken once
  logic        badReg, badNext;            // Hint sanity flag
  nsid_word_t  agidReg, agidNext;          // Reported group id
  logic        noticeReg, noticeNext;      // Change notice pulse
  nsid_state_e stateReg, stateNext;        // Read engine state
  nsid_byte_t  addrReg, addrNext;          // Captured address
  nsid_byte_t  dataReg, dataNext;          // Answer byte
  logic        validReg, validNext;        // Answer strobe
  logic        failReg, failNext;          // Registered verdicts
  logic        okReg, okNext;
  nsid_word_t  agidLive;                   // Group id after gating
  logic        multOk;                     // Granularity checks

  nsid_chk_if chk ();
  nsid_wp_gate uGate (.chk(chk));
  assign chk.wrReq  = wrReq;
  assign chk.wrProt = writeProtected;

  // Zero-based counts: a multiple means (a+1) divides (b+1)
  function automatic logic isMult(input nsid_half_t b, input nsid_half_t a);
    logic [16:0] bb;
    logic [16:0] aa;
    bb = {1'b0, b} + 17'h00001;
    aa = {1'b0, a} + 17'h00001;
    isMult = ((bb % aa) == 17'h00000);
  endfunction

  // Group id gated by reporting support
  always_comb begin
    agidLive = accessReportSupported ? accessGroupId : `NSID_RST_WORD; // [R9] [R10]
    multOk = isMult(prefDeallocGran, prefDeallocAlign)                  // [R4]
           & isMult(optimalWriteSize, prefWriteGran)                    // [R7] [R16]
           & (optimalWriteSize <= maxTransferLimit);                    // [R7]
  end

  // Field image: only reformat or the first load after reset may move the hints
  always_comb begin
    alignNext  = alignReg;
    dGranNext  = dGranReg;
    dAlignNext = dAlignReg;
    owsNext    = owsReg;
    optNext    = optReg;
    loadedNext = 1'b1;
    badNext    = badReg;
    if (reformatDone || !loadedReg) begin                               // [R8]
      alignNext  = prefWriteAlign;                                      // [R1]
      dGranNext  = prefDeallocGran;                                     // [R2]
      dAlignNext = prefDeallocAlign;                                    // [R5]
      owsNext    = optimalWriteSize;                                    // [R6]
      optNext    = optimParamsSupported;
      // Only meaningful when the hints are reported at all
      badNext    = optimParamsSupported & ~multOk;
    end
  end

  // Group id tracking and change notice
  always_comb begin
    agidNext   = agidLive;
    noticeNext = (agidLive != agidReg) & accessReportSupported
               & accessNoticeEnabled & loadedReg;                       // [R11]
  end

  // Read engine: take address, look up byte, answer one cycle strobe
  always_comb begin
    stateNext = stateReg;
    addrNext  = addrReg;
    dataNext  = dataReg;
    validNext = 1'b0;
    failNext  = chk.wrFail;                                             // [R12]
    okNext    = chk.wrPass;
    case (stateReg)
      NSID_IDLE: begin
        if (rdReq) begin
          addrNext  = rdAddr;
          stateNext = NSID_LOAD;
        end
      end
      NSID_LOAD: begin
        dataNext  = `NSID_RST_BYTE;                                     // [R17]
        // Deallocate and write size hints reserved without optimisation support; write alignment always returned
        if (addrReg == `NSID_OFF_PWALIGN) begin
          dataNext = alignReg[7:0];                                     // [R1]
        end else if (addrReg == `NSID_OFF_PWALIGN + 8'd1) begin
          dataNext = alignReg[15:8];
        end else if (addrReg == `NSID_OFF_DGRAN) begin
          dataNext = optReg ? dGranReg[7:0] : `NSID_RST_BYTE;           // [R2] [R3]
        end else if (addrReg == `NSID_OFF_DGRAN + 8'd1) begin
          dataNext = optReg ? dGranReg[15:8] : `NSID_RST_BYTE;          // [R3]
        end else if (addrReg == `NSID_OFF_DALIGN) begin
          dataNext = optReg ? dAlignReg[7:0] : `NSID_RST_BYTE;          // [R5] [R3]
        end else if (addrReg == `NSID_OFF_DALIGN + 8'd1) begin
          dataNext = optReg ? dAlignReg[15:8] : `NSID_RST_BYTE;         // [R3]
        end else if (addrReg == `NSID_OFF_OWSIZE) begin
          dataNext = optReg ? owsReg[7:0] : `NSID_RST_BYTE;             // [R6] [R3]
        end else if (addrReg == `NSID_OFF_OWSIZE + 8'd1) begin
          dataNext = optReg ? owsReg[15:8] : `NSID_RST_BYTE;            // [R3]
        end else if (addrReg >= `NSID_OFF_AGID &&
                     addrReg <= `NSID_OFF_AGID + 8'd3) begin
          // Little-endian byte pick of the group id
          dataNext = agidReg[8*(addrReg - `NSID_OFF_AGID) +: 8];        // [R9]
        end else if (addrReg == `NSID_OFF_ATTR) begin
          dataNext = {7'h00, writeProtected};                           // [R12] [R13]
        end else if (addrReg == `NSID_OFF_SETID) begin
          dataNext = storageSetSupported ? storageSetId[7:0]
                                         : `NSID_RST_BYTE;              // [R14]
        end else if (addrReg == `NSID_OFF_SETID + 8'd1) begin
          dataNext = storageSetSupported ? storageSetId[15:8]
                                         : `NSID_RST_BYTE;              // [R14]
        end else if (addrReg == `NSID_OFF_ENDURANCE_GROUP_ID) begin
          dataNext = enduranceSupported ? enduranceGroupId[7:0]
                                        : `NSID_RST_BYTE;               // [R15]
        end else if (addrReg == `NSID_OFF_ENDURANCE_GROUP_ID + 8'd1) begin
          dataNext = enduranceSupported ? enduranceGroupId[15:8]
                                        : `NSID_RST_BYTE;               // [R15]
        end
        stateNext = NSID_ANS;
      end
      NSID_ANS: begin
        validNext = 1'b1;
        stateNext = NSID_IDLE;
      end
      default: begin
        stateNext = NSID_IDLE;
      end
    endcase
  end

  // All state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alignReg  <= `NSID_RST_HALF;
      dGranReg  <= `NSID_RST_HALF;
      dAlignReg <= `NSID_RST_HALF;
      owsReg    <= `NSID_RST_HALF;
      optReg    <= 1'b0;
      loadedReg <= 1'b0;
      badReg    <= 1'b0;
      agidReg   <= `NSID_RST_WORD;
      noticeReg <= 1'b0;
      stateReg  <= NSID_IDLE;
      addrReg   <= `NSID_RST_BYTE;
      dataReg   <= `NSID_RST_BYTE;
      validReg  <= 1'b0;
      failReg   <= 1'b0;
      okReg     <= 1'b0;
    end else begin
      alignReg  <= alignNext;
      dGranReg  <= dGranNext;
      dAlignReg <= dAlignNext;
      owsReg    <= owsNext;
      optReg    <= optNext;
      loadedReg <= loadedNext;
      badReg    <= badNext;
      agidReg   <= agidNext;
      noticeReg <= noticeNext;
      stateReg  <= stateNext;
      addrReg   <= addrNext;
      dataReg   <= dataNext;
      validReg  <= validNext;
      failReg   <= failNext;
      okReg     <= okNext;
    end
  end

  // Outputs straight from flip-flops
  assign rdValid            = validReg;
  assign rdData             = dataReg;
  assign wrFail             = failReg;
  assign wrOk               = okReg;
  assign accessChangeNotice = noticeReg;
  assign hintsInconsistent  = badReg;
endmodule
`default_nettype wire

//--- dv/nsid_fields_assertions.sv
// Port-level concurrent checks for the identify field block
`timescale 1ns/1ps
`default_nettype none
module nsid_fields_assertions (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 rdReq,
  input wire logic                 rdValid,
  input wire logic                 wrReq,
  input wire logic                 writeProtected,
  input wire logic                 wrFail,
  input wire logic                 wrOk,
  input wire logic                 accessChangeNotice,
  input wire nsid_pkg::nsid_word_t accessGroupId,
  input wire logic                 accessReportSupported,
  input wire logic                 accessNoticeEnabled
);
  import nsid_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Answer only for a request taken three edges back
  sequence sRdTaken;
    $past(rdReq, 3);
  endsequence
  // Gated group id quiet over three edges
  sequence sIdQuiet;
    ($stable(accessGroupId) && $stable(accessReportSupported))[*3];
  endsequence
  AST_RD_LAT: assert property (rdValid |-> sRdTaken)
    else $error("read answer without request three cycles back");
  AST_RD_PULSE: assert property (rdValid |=> !rdValid)
    else $error("read valid longer than one cycle");
  AST_WR_FAIL: assert property (wrReq && writeProtected |=> wrFail && !wrOk)
    else $error("protected write not failed");
  AST_WR_OK: assert property (wrReq && !writeProtected |=> wrOk && !wrFail)
    else $error("unprotected write not passed");
  AST_WR_IDLE: assert property (!wrReq |=> !wrFail && !wrOk)
    else $error("write answer without request");
  AST_WR_EXCL: assert property (!(wrFail && wrOk))
    else $error("write both failed and passed");
  AST_NOTICE_EN: assert property (accessChangeNotice |->
    $past(accessReportSupported && accessNoticeEnabled))
    else $error("notice while not enabled");
  AST_ID_QUIET: assert property (sIdQuiet |-> !accessChangeNotice)
    else $error("notice without group id change");
endmodule
bind nsid_fields nsid_fields_assertions i_chk (.clk(clk), .rst(rst),
  .rdReq(rdReq), .rdValid(rdValid), .wrReq(wrReq),
  .writeProtected(writeProtected), .wrFail(wrFail), .wrOk(wrOk),
  .accessChangeNotice(accessChangeNotice), .accessGroupId(accessGroupId),
  .accessReportSupported(accessReportSupported),
  .accessNoticeEnabled(accessNoticeEnabled));
`default_nettype wire

//--- dv/nsid_host_model.sv
// Host model issuing single-byte identify reads
`timescale 1ns/1ps
`default_nettype none
module nsid_host_model (
  input  wire logic                 clk,
  output logic                      rdReq,
  output nsid_pkg::nsid_byte_t      rdAddr,
  input  wire logic                 rdValid,
  input  wire nsid_pkg::nsid_byte_t rdData
);
  import nsid_pkg::*;
  initial begin
    rdReq = 1'b0;
    rdAddr = 8'h00;
  end
  // Address inverted once taken, so a late sample is caught
  task automatic readByte(input nsid_byte_t a, output nsid_byte_t d,
                          output bit ok);
    ok = 1'b0;
    d = 8'h00;
    rdReq = 1'b1;
    rdAddr = a;
    @(posedge clk);
    #1;
    rdReq = 1'b0;
    rdAddr = ~a;
    for (int n = 0; n < 6 && !ok; n++) begin
      @(posedge clk);
      #1;
      ok = (rdValid === 1'b1);
      d = rdData;
    end
  endtask
endmodule
`default_nettype wire

//--- dv/namespace_identify_fields_test.sv
// Self-checking bench for the identify field block
`timescale 1ns/1ps
`default_nettype none
module namespace_identify_fields_test;
  import nsid_pkg::*;
  logic       clk, rst, optim, refmt, rep, nEn, wp, ssup, esup, wrReq;
  logic       rdReq, rdValid, wrFail, wrOk, notice, incons;
  nsid_half_t wAlign, dGran, dAlign, oSize, wGran, maxXfer, setId, endId;
  nsid_word_t grpId;
  nsid_byte_t rdAddr, rdData;
  int         errorCnt = 0;
  int         checks = 0;
  nsid_fields i_nsid_fields (.clk(clk), .rst(rst), .prefWriteAlign(wAlign),
    .prefDeallocGran(dGran), .prefDeallocAlign(dAlign),
    .optimalWriteSize(oSize), .prefWriteGran(wGran),
    .maxTransferLimit(maxXfer), .optimParamsSupported(optim),
    .reformatDone(refmt), .accessGroupId(grpId),
    .accessReportSupported(rep), .accessNoticeEnabled(nEn),
    .writeProtected(wp), .storageSetId(setId), .storageSetSupported(ssup),
    .enduranceGroupId(endId), .enduranceSupported(esup), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData), .wrReq(wrReq),
    .wrFail(wrFail), .wrOk(wrOk), .accessChangeNotice(notice),
    .hintsInconsistent(incons));
  nsid_host_model i_nsid_host_model (.clk(clk), .rdReq(rdReq),
    .rdAddr(rdAddr), .rdValid(rdValid), .rdData(rdData));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic report_and_stop();
    if (errorCnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errorCnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Expected byte from current sources, little endian halves
  function automatic nsid_byte_t expByte(input nsid_byte_t a);
    nsid_half_t h;
    case (a)
      8'h42, 8'h43: h = wAlign;
      8'h44, 8'h45: h = optim ? dGran : 16'h0000;
      8'h46, 8'h47: h = optim ? dAlign : 16'h0000;
      8'h48, 8'h49: h = optim ? oSize : 16'h0000;
      8'h5c, 8'h5d: h = rep ? grpId[15:0] : 16'h0000;
      8'h5e, 8'h5f: h = rep ? grpId[31:16] : 16'h0000;
      8'h63: h = {7'h00, wp, 8'h00};
      8'h64, 8'h65: h = ssup ? setId : 16'h0000;
      8'h66, 8'h67: h = esup ? endId : 16'h0000;
      default: h = 16'h0000;
    endcase
    return a[0] ? h[15:8] : h[7:0];
  endfunction
  task automatic rdRange(input nsid_byte_t lo, input nsid_byte_t hi);
    nsid_byte_t d;
    bit ok;
    for (int a = lo; a <= hi; a++) begin
      i_nsid_host_model.readByte(8'(a), d, ok);
      if (!ok) errorCnt++;
      if (!ok) report_and_stop();
      check(d, expByte(8'(a)));
    end
  endtask
  // Image relatch, pulse then let the load land
  task automatic reload();
    refmt = 1'b1;
    repeat (2) begin
      @(posedge clk);
      #1;
      refmt = 1'b0;
    end
  endtask
  task automatic tFields();
    reload();
    rdRange(8'h42, 8'h67);
    check({7'h00, incons}, 8'h00);
  endtask
  task automatic tUnsupported();
    {optim, rep, ssup, esup, wp} = 5'h00;
    reload();
    rdRange(8'h42, 8'h67);
    {optim, rep, ssup, esup, wp} = 5'h1f;
    reload();
  endtask
  task automatic tReformat();
    nsid_byte_t d;
    bit         ok;
    wAlign = 16'h0020;
    oSize = 16'h0004;
    // Sources moved without reformat: the image keeps the old hint
    i_nsid_host_model.readByte(8'h42, d, ok);
    check({7'h00, ok}, 8'h01);
    check(d, 8'h03);
    reload();
    rdRange(8'h42, 8'h49);
    check({7'h00, incons}, 8'h01);
  endtask
  task automatic tWrite();
    wrReq = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check({6'h00, wrFail, wrOk}, 8'h02);
    wp = 1'b0;
    // Verdict follows the edge that samples the request, one cycle on
    @(posedge clk);
    #1;
    check({6'h00, wrFail, wrOk}, 8'h01);
    wrReq = 1'b0;
    @(posedge clk);
    #1;
    check({6'h00, wrFail, wrOk}, 8'h00);
    @(posedge clk);
    #1;
    check({6'h00, wrFail, wrOk}, 8'h00);
  endtask
  task automatic tNotice(input logic en, input logic [7:0] exp);
    int n;
    n = 0;
    nEn = en;
    grpId = grpId + 32'h00000001;
    repeat (5) begin
      @(posedge clk);
      #1;
      if (notice === 1'b1) n++;
    end
    check(8'(n), exp);
  endtask
  initial begin
    rst = 1'b1;
    {refmt, wrReq, nEn} = 3'h0;
    {optim, rep, ssup, esup, wp} = 5'h1f;
    {wAlign, dAlign, dGran, wGran} = {16'h0003, 16'h0003, 16'h0007, 16'h0007};
    {oSize, maxXfer, setId, endId} = {16'h000f, 16'h0010, 16'h1234, 16'h5678};
    grpId = 32'h0a0b0c0d;
    repeat (4) @(posedge clk);
    #1;
    rst = 1'b0;
    @(posedge clk);
    #1;
    tFields();
    tUnsupported();
    tReformat();
    tWrite();
    tNotice(1'b1, 8'h01);
    tNotice(1'b0, 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
